// ==== bdtb_far_end.sv ====
// Purpose: emulator side model driving the bus clock and tag pins
// Assumes: bus clock runs free, tag pins change on the same clock edge as its rise
// Notes: tag requests come from the bench as active-high levels
`timescale 1ns/1ps
`default_nettype none
module bdtb_far_end #(
	parameter int HALF_PERIOD = 4
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// tag requests from the bench
	input  wire logic tagUpperReq,
	input  wire logic tagLowerReq,
	// pins toward the block
	output logic      busClkPin,
	output logic      upperTagInput,
	output logic      lowerTagInput
);
	logic [7:0] phaseCnt;
	logic       phaseEnd;

	assign phaseEnd = (phaseCnt == 8'(HALF_PERIOD - 1));

	// bus clock divider
	always_ff @(posedge sys_clk) begin
		if (sys_rst || phaseEnd) begin
			phaseCnt <= 8'h00;
		end else begin
			phaseCnt <= phaseCnt + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			busClkPin <= 1'b0;
		end else if (phaseEnd) begin
			busClkPin <= ~busClkPin;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			upperTagInput <= 1'b1;
			lowerTagInput <= 1'b1;
		end else if (phaseEnd && !busClkPin) begin
			upperTagInput <= ~tagUpperReq;
			lowerTagInput <= ~tagLowerReq;
		end
	end
endmodule // bdtb_far_end
`default_nettype wire

// ==== bdtb_pkg.sv ====
// Purpose: constants and types shared by the debug register block
// Assumes: byte-wide registers at offsets from a relocatable base
// Notes: all offsets are relative to the base input
package bdtb_pkg;
	// register offsets from the block base
	localparam logic [15:0] OFS_CTRL_ONE    = 16'h0020;
	localparam logic [15:0] OFS_STATUS_CTRL = 16'h0021;
	localparam logic [15:0] OFS_TRACE_HIGH  = 16'h0022;
	localparam logic [15:0] OFS_TRACE_LOW   = 16'h0023;
	localparam logic [15:0] OFS_ENTRY_COUNT = 16'h0024;
	localparam logic [15:0] OFS_CMP_C_EXT   = 16'h0025;
	localparam logic [15:0] OFS_CMP_C_HIGH  = 16'h0026;
	localparam logic [15:0] OFS_CMP_C_LOW   = 16'h0027;
	localparam logic [15:0] OFS_CTRL_TWO    = 16'h0028;
	localparam logic [15:0] OFS_CTRL_THREE  = 16'h0029;
	localparam logic [15:0] OFS_CMP_A_EXT   = 16'h002a;
	localparam logic [15:0] OFS_CMP_A_HIGH  = 16'h002b;
	localparam logic [15:0] OFS_CMP_A_LOW   = 16'h002c;
	localparam logic [15:0] OFS_CMP_B_EXT   = 16'h002d;
	localparam logic [15:0] OFS_CMP_B_HIGH  = 16'h002e;
	localparam logic [15:0] OFS_CMP_B_LOW   = 16'h002f;
	// control one fields
	localparam int CTL1_TRACE_EN  = 7;
	localparam int CTL1_ARMED     = 6;
	localparam int CTL1_TRIG_SEL  = 5;
	localparam int CTL1_ZERO      = 2;
	localparam logic [7:0] CTL1_WRITE_MASK = 8'hfb;
	localparam logic [7:0] ARM_ONLY_MASK   = 8'hc0;
	// status fields
	localparam int STS_FLAG_A = 7;
	localparam int STS_FLAG_B = 6;
	localparam int STS_FLAG_C = 5;
	localparam logic [7:0] STS_WRITE_MASK = 8'h0f;
	localparam logic [7:0] STS_FLAG_MASK  = 8'he0;
	// control two fields
	localparam int CTL2_AB_BKPT_EN = 7;
	localparam int CTL2_AB_TAG     = 4;
	localparam int CTL2_C_BKPT_EN  = 3;
	localparam int CTL2_C_TAG      = 2;
	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	// capture mode encodings
	typedef enum logic [1:0] {
		CAP_NORMAL,
		CAP_LOOP,
		CAP_DETAIL,
		CAP_PROFILE
	} bdtb_capture_e;
endpackage

// ==== bdtb_regs.sv ====
// Purpose: register map, tag sampling and bus observation of the debug unit
// Assumes: one clock, synchronous active-high reset, relocatable base
// Notes: read data stands only in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module bdtb_regs (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clkEn,
	// register port
	input  wire logic [15:0]           regBase,
	input  wire logic [15:0]           regAddr,
	input  wire logic [7:0]            regWdata,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output logic      [7:0]            regRdata,
	// tag pins and bus clock pin
	input  wire logic                  busClkPin,
	input  wire logic                  upperTagInput,
	input  wire logic                  lowerTagInput,
	input  wire logic                  wideOrNarrowMode,
	input  wire logic                  lowByteStrobe,
	output logic                       tagHigh,
	output logic                       tagLow,
	// bus observation
	input  wire logic                  busValid,
	input  wire logic                  extAccess,
	input  wire logic [15:0]           intAddr,
	input  wire logic [15:0]           intData,
	input  wire logic [15:0]           extAddr,
	input  wire logic [15:0]           extData,
	output logic      [15:0]           obsAddr,
	output logic      [15:0]           obsData,
	// trace storage state
	input  wire logic [15:0]           traceWord,
	input  wire logic [5:0]            entryCount,
	input  wire logic                  bufferFullFlag,
	// control outputs
	output logic      [7:0]            ctrlOne,
	output logic      [7:0]            statusCtrl,
	output logic      [7:0]            ctrlTwo,
	output logic      [7:0]            ctrlThree,
	output bdtb_pkg::bdtb_capture_e    captureModeField,
	output logic                       matchA,
	output logic                       matchB,
	output logic                       matchC,
	output logic                       abBreakRequest,
	output logic                       cBreakRequest
);
	logic [15:0] offset;
	logic        wrCtl1;
	logic        wrSts;
	logic        wrOther;
	logic        armed;
	logic [7:0]  next_ctrlOne;
	logic        armWriteOne;
	logic [7:0]  cmpCExt;
	logic [15:0] cmpC;
	logic [7:0]  cmpAExt;
	logic [15:0] cmpA;
	logic [7:0]  cmpBExt;
	logic [15:0] cmpB;
	logic        obsValid;
	logic        eSync1;
	logic        eSync2;
	logic        eSync3;
	logic        hiSync1;
	logic        hiSync2;
	logic        loSync1;
	logic        loSync2;
	logic        busClkFall;
	logic        taggingOn;
	logic        setA;
	logic        setB;
	logic        setC;
	logic        clearFlags;

	function automatic logic isWrite(input logic [15:0] ofs, input logic [15:0] target);
		isWrite = regWrite && (ofs == target);
	endfunction

	assign offset = regAddr - regBase;
	assign armed = ctrlOne[bdtb_pkg::CTL1_ARMED];
	assign wrCtl1 = isWrite(offset, bdtb_pkg::OFS_CTRL_ONE);
	assign wrSts = isWrite(offset, bdtb_pkg::OFS_STATUS_CTRL);
	assign wrOther = regWrite && !armed;

	// control one next value
	always_comb begin
		next_ctrlOne = (regWdata & bdtb_pkg::CTL1_WRITE_MASK);
		if (armed) begin
			next_ctrlOne = (regWdata & bdtb_pkg::ARM_ONLY_MASK)
				| (ctrlOne & ~bdtb_pkg::ARM_ONLY_MASK);
		end
		if (regWdata[bdtb_pkg::CTL1_ARMED] && !regWdata[bdtb_pkg::CTL1_TRACE_EN]) begin
			next_ctrlOne[bdtb_pkg::CTL1_ARMED] = 1'b0;
			next_ctrlOne[bdtb_pkg::CTL1_TRACE_EN] = 1'b0;
		end
	end

	assign armWriteOne = wrCtl1 && !ctrlTwo[bdtb_pkg::CTL2_AB_BKPT_EN]
		&& next_ctrlOne[bdtb_pkg::CTL1_ARMED];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrlOne <= bdtb_pkg::RESET_BYTE;
		end else if (clkEn && wrCtl1 && !ctrlTwo[bdtb_pkg::CTL2_AB_BKPT_EN]) begin
			ctrlOne <= next_ctrlOne;
		end
	end

	assign captureModeField = bdtb_pkg::bdtb_capture_e'(ctrlOne[1:0]);

	assign clearFlags = armWriteOne || (wrSts && !armed);
	assign setA = armed && matchA;
	assign setB = armed && matchB;
	assign setC = armed && matchC;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			statusCtrl <= bdtb_pkg::RESET_BYTE;
		end else if (clkEn) begin
			if (clearFlags) begin
				statusCtrl[7:5] <= 3'h0;
			end
			if (setA) begin
				statusCtrl[bdtb_pkg::STS_FLAG_A] <= 1'b1;
			end
			if (setB) begin
				statusCtrl[bdtb_pkg::STS_FLAG_B] <= 1'b1;
			end
			if (setC) begin
				statusCtrl[bdtb_pkg::STS_FLAG_C] <= 1'b1;
			end
			statusCtrl[4] <= 1'b0;
			if (wrSts && !armed) begin
				statusCtrl[3:0] <= regWdata[3:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrlTwo <= bdtb_pkg::RESET_BYTE;
			ctrlThree <= bdtb_pkg::RESET_BYTE;
		end else if (clkEn && wrOther) begin
			if (offset == bdtb_pkg::OFS_CTRL_TWO) begin
				ctrlTwo <= regWdata;
			end
			if (offset == bdtb_pkg::OFS_CTRL_THREE) begin
				ctrlThree <= regWdata;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cmpCExt <= bdtb_pkg::RESET_BYTE;
			cmpAExt <= bdtb_pkg::RESET_BYTE;
			cmpBExt <= bdtb_pkg::RESET_BYTE;
			cmpC <= bdtb_pkg::RESET_WORD;
			cmpA <= bdtb_pkg::RESET_WORD;
			cmpB <= bdtb_pkg::RESET_WORD;
		end else if (clkEn && wrOther) begin
			unique case (offset)
				bdtb_pkg::OFS_CMP_C_EXT: begin
					cmpCExt <= regWdata;
				end
				bdtb_pkg::OFS_CMP_C_HIGH: begin
					cmpC[15:8] <= regWdata;
				end
				bdtb_pkg::OFS_CMP_C_LOW: begin
					cmpC[7:0] <= regWdata;
				end
				bdtb_pkg::OFS_CMP_A_EXT: begin
					cmpAExt <= regWdata;
				end
				bdtb_pkg::OFS_CMP_A_HIGH: begin
					cmpA[15:8] <= regWdata;
				end
				bdtb_pkg::OFS_CMP_A_LOW: begin
					cmpA[7:0] <= regWdata;
				end
				bdtb_pkg::OFS_CMP_B_EXT: begin
					cmpBExt <= regWdata;
				end
				bdtb_pkg::OFS_CMP_B_HIGH: begin
					cmpB[15:8] <= regWdata;
				end
				bdtb_pkg::OFS_CMP_B_LOW: begin
					cmpB[7:0] <= regWdata;
				end
				default: begin
				end
			endcase
		end
	end

	// read data, one cycle later
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			regRdata <= bdtb_pkg::RESET_BYTE;
		end else if (clkEn) begin
			regRdata <= bdtb_pkg::RESET_BYTE;
			if (regRead) begin
				unique case (offset)
					bdtb_pkg::OFS_CTRL_ONE:    regRdata <= ctrlOne;
					bdtb_pkg::OFS_STATUS_CTRL: regRdata <= statusCtrl;
					bdtb_pkg::OFS_TRACE_HIGH:  regRdata <= traceWord[15:8];
					bdtb_pkg::OFS_TRACE_LOW:   regRdata <= traceWord[7:0];
					bdtb_pkg::OFS_ENTRY_COUNT: regRdata <= {bufferFullFlag, 1'b0, entryCount};
					bdtb_pkg::OFS_CMP_C_EXT:   regRdata <= cmpCExt;
					bdtb_pkg::OFS_CMP_C_HIGH:  regRdata <= cmpC[15:8];
					bdtb_pkg::OFS_CMP_C_LOW:   regRdata <= cmpC[7:0];
					bdtb_pkg::OFS_CTRL_TWO:    regRdata <= ctrlTwo;
					bdtb_pkg::OFS_CTRL_THREE:  regRdata <= ctrlThree;
					bdtb_pkg::OFS_CMP_A_EXT:   regRdata <= cmpAExt;
					bdtb_pkg::OFS_CMP_A_HIGH:  regRdata <= cmpA[15:8];
					bdtb_pkg::OFS_CMP_A_LOW:   regRdata <= cmpA[7:0];
					bdtb_pkg::OFS_CMP_B_EXT:   regRdata <= cmpBExt;
					bdtb_pkg::OFS_CMP_B_HIGH:  regRdata <= cmpB[15:8];
					bdtb_pkg::OFS_CMP_B_LOW:   regRdata <= cmpB[7:0];
					default:                   regRdata <= bdtb_pkg::RESET_BYTE;
				endcase
			end
		end
	end

	// pin synchronisers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			eSync1 <= 1'b0;
			eSync2 <= 1'b0;
			eSync3 <= 1'b0;
			hiSync1 <= 1'b1;
			hiSync2 <= 1'b1;
			loSync1 <= 1'b1;
			loSync2 <= 1'b1;
		end else if (clkEn) begin
			eSync1 <= busClkPin;
			eSync2 <= eSync1;
			eSync3 <= eSync2;
			hiSync1 <= upperTagInput;
			hiSync2 <= hiSync1;
			loSync1 <= lowerTagInput;
			loSync2 <= loSync1;
		end
	end

	assign busClkFall = eSync3 && !eSync2;
	assign taggingOn = ctrlTwo[bdtb_pkg::CTL2_AB_TAG] || ctrlTwo[bdtb_pkg::CTL2_C_TAG]
		|| (ctrlOne[bdtb_pkg::CTL1_TRACE_EN] && ctrlOne[bdtb_pkg::CTL1_TRIG_SEL]);

	// tag capture at bus clock fall
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tagHigh <= 1'b0;
			tagLow <= 1'b0;
		end else if (clkEn && busClkFall) begin
			tagHigh <= taggingOn && !hiSync2;
			tagLow <= taggingOn && wideOrNarrowMode && lowByteStrobe && !loSync2;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			obsAddr <= bdtb_pkg::RESET_WORD;
			obsData <= bdtb_pkg::RESET_WORD;
			obsValid <= 1'b0;
		end else if (clkEn) begin
			obsValid <= busValid;
			if (busValid) begin
				obsAddr <= extAccess ? extAddr : intAddr;
				obsData <= extAccess ? extData : intData;
			end
		end
	end

	// comparator matches
	assign matchA = obsValid && (obsAddr == cmpA);
	assign matchB = obsValid && (obsAddr == cmpB);
	assign matchC = obsValid && (obsAddr == cmpC);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			abBreakRequest <= 1'b0;
			cBreakRequest <= 1'b0;
		end else if (clkEn) begin
			abBreakRequest <= !ctrlOne[bdtb_pkg::CTL1_TRACE_EN]
				&& ctrlTwo[bdtb_pkg::CTL2_AB_BKPT_EN] && (matchA || matchB);
			cBreakRequest <= !ctrlOne[bdtb_pkg::CTL1_TRACE_EN]
				&& ctrlTwo[bdtb_pkg::CTL2_C_BKPT_EN] && matchC;
		end
	end

	a_armed_lock: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && armed && regWrite && offset == bdtb_pkg::OFS_CTRL_TWO |=> $stable(ctrlTwo))
		else $error("control two changed while armed");
	a_arm_needs_en: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && wrCtl1 && !ctrlTwo[bdtb_pkg::CTL2_AB_BKPT_EN] && regWdata[bdtb_pkg::CTL1_ARMED]
		&& !regWdata[bdtb_pkg::CTL1_TRACE_EN]
		|=> !ctrlOne[bdtb_pkg::CTL1_ARMED] && !ctrlOne[bdtb_pkg::CTL1_TRACE_EN])
		else $error("armed set without trace enable");
	a_bkp_blocks_c1: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && wrCtl1 && ctrlTwo[bdtb_pkg::CTL2_AB_BKPT_EN] |=> $stable(ctrlOne))
		else $error("control one written in breakpoint mode");
	a_flags_clear: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && armWriteOne && !matchA && !matchB && !matchC |=> statusCtrl[7:5] == 3'h0)
		else $error("flags not cleared on arming");
	a_zero_bits: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!ctrlOne[bdtb_pkg::CTL1_ZERO] && !statusCtrl[4])
		else $error("reserved bit reads one");
	a_count_read: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && regRead && offset == bdtb_pkg::OFS_ENTRY_COUNT
		|=> regRdata == {$past(bufferFullFlag), 1'b0, $past(entryCount)})
		else $error("count register read wrong");
	a_trace_high: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && regRead && offset == bdtb_pkg::OFS_TRACE_HIGH
		|=> regRdata == $past(traceWord[15:8]))
		else $error("trace high byte read wrong");
	a_ext_observe: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && busValid && extAccess |=> obsAddr == $past(extAddr) && obsData == $past(extData))
		else $error("external access not observed");
	a_tag_high: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && busClkFall && taggingOn && !hiSync2 |=> tagHigh)
		else $error("upper tag missed");
	a_c_break: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && matchC && ctrlTwo[bdtb_pkg::CTL2_C_BKPT_EN]
		&& !ctrlOne[bdtb_pkg::CTL1_TRACE_EN] |=> cBreakRequest)
		else $error("comparator C break missed");
	a_shared_write: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && wrOther && offset == bdtb_pkg::OFS_CTRL_THREE |=> ctrlThree == $past(regWdata))
		else $error("control three write lost");
endmodule // bdtb_regs
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the debug register block
// Assumes: register port with read data one cycle after the strobe
// Notes: far end model drives the bus clock and tag pins
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                   sys_clk, sys_rst, clkEn;
	logic [15:0]            regBase, regAddr;
	logic [7:0]             regWdata, regRdata;
	logic                   regWrite, regRead;
	logic                   busClkPin, upperTagInput, lowerTagInput;
	logic                   tagUpperReq, tagLowerReq;
	logic                   wideOrNarrowMode, lowByteStrobe, tagHigh, tagLow;
	logic                   busValid, extAccess;
	logic [15:0]            intAddr, extAddr, obsAddr, traceWord, intData, extData, obsData;
	logic [5:0]             entryCount;
	logic                   bufferFullFlag;
	logic [7:0]             ctrlOne, statusCtrl, ctrlTwo, ctrlThree;
	bdtb_pkg::bdtb_capture_e captureModeField;
	logic                   abBreakRequest, cBreakRequest;
	int                     err_total, tests_run, cycles;
	logic [15:0]            rwOfs [10] = '{16'h0025, 16'h0026, 16'h0027, 16'h0029, 16'h002a,
		16'h002b, 16'h002c, 16'h002d, 16'h002e, 16'h002f};

	bdtb_regs i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
		.regBase(regBase), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .busClkPin(busClkPin),
		.upperTagInput(upperTagInput), .lowerTagInput(lowerTagInput),
		.wideOrNarrowMode(wideOrNarrowMode), .lowByteStrobe(lowByteStrobe),
		.tagHigh(tagHigh), .tagLow(tagLow), .busValid(busValid), .extAccess(extAccess),
		.intAddr(intAddr), .intData(intData), .extAddr(extAddr), .extData(extData),
		.obsAddr(obsAddr), .obsData(obsData), .traceWord(traceWord), .entryCount(entryCount),
		.bufferFullFlag(bufferFullFlag), .ctrlOne(ctrlOne), .statusCtrl(statusCtrl),
		.ctrlTwo(ctrlTwo), .ctrlThree(ctrlThree), .captureModeField(captureModeField),
		.matchA(), .matchB(), .matchC(), .abBreakRequest(abBreakRequest),
		.cBreakRequest(cBreakRequest));

	bdtb_far_end i_far (.sys_clk(sys_clk), .sys_rst(sys_rst), .tagUpperReq(tagUpperReq),
		.tagLowerReq(tagLowerReq), .busClkPin(busClkPin), .upperTagInput(upperTagInput),
		.lowerTagInput(lowerTagInput));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic final_report;
		if (err_total == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr  <= regBase + ofs;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask

	task automatic rdchk(input logic [15:0] ofs, input logic [7:0] exp);
		@(posedge sys_clk);
		regAddr <= regBase + ofs;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 chk({8'h00, regRdata}, {8'h00, exp});
	endtask

	// one observed bus cycle, then observed address and data
	task automatic hit(input logic ext, input logic [15:0] eAddr, input logic [15:0] iAddr,
		input logic [15:0] expObs);
		@(posedge sys_clk);
		busValid  <= 1'b1;
		extAccess <= ext;
		extAddr   <= eAddr;
		intAddr   <= iAddr;
		extData   <= ~eAddr;
		intData   <= ~iAddr;
		@(posedge sys_clk);
		busValid <= 1'b0;
		#1 chk(obsAddr, expObs);
		chk(obsData, ~expObs);
		@(posedge sys_clk);
		#1;
	endtask

	task automatic t_map;
		regBase <= 16'h3f00;
		foreach (rwOfs[i]) begin
			rdchk(rwOfs[i], 8'h00);
			wr(rwOfs[i], rwOfs[i][7:0] ^ 8'h5a);
			rdchk(rwOfs[i], rwOfs[i][7:0] ^ 8'h5a);
		end
		wr(16'h0028, 8'h7e);
		rdchk(16'h0028, 8'h7e);
		wr(16'h0028, 8'h00);
		rdchk(16'h0030, 8'h00);
		regBase <= 16'h0000;
		rdchk(16'h3f2b, 8'h00);
		rdchk(16'h002b, 8'h71);
		regBase <= 16'h3f00;
	endtask

	task automatic t_readonly;
		traceWord      <= 16'ha5c3;
		entryCount     <= 6'h2b;
		bufferFullFlag <= 1'b1;
		wr(16'h0022, 8'h00);
		rdchk(16'h0022, 8'ha5);
		rdchk(16'h0023, 8'hc3);
		rdchk(16'h0024, 8'hab);
	endtask

	task automatic t_ctrl;
		wr(16'h0020, 8'hbf);
		rdchk(16'h0020, 8'hbb);
		for (int m = 0; m < 4; m++) begin
			wr(16'h0020, {6'h00, 2'(m)});
			#1 chk({14'h0000, captureModeField}, 16'(m));
		end
		wr(16'h0021, 8'hff);
		rdchk(16'h0021, 8'h0f);
		wr(16'h0020, 8'h83);
		wr(16'h0020, 8'h43);
		rdchk(16'h0020, 8'h03);
		wr(16'h0021, 8'h00);
		wr(16'h0020, 8'hc1);
		wr(16'h0028, 8'h55);
		wr(16'h0021, 8'h03);
		rdchk(16'h0028, 8'h00);
		rdchk(16'h0021, 8'h00);
		wr(16'h0020, 8'h9e);
		rdchk(16'h0020, 8'h81);
		wr(16'h0020, 8'h00);
		wr(16'h0028, 8'h80);
		wr(16'h0020, 8'h83);
		rdchk(16'h0020, 8'h00);
		wr(16'h0028, 8'h00);
	endtask

	task automatic t_match;
		wr(16'h002b, 8'h12);
		wr(16'h002c, 8'h34);
		wr(16'h0026, 8'h56);
		wr(16'h0027, 8'h78);
		wr(16'h0020, 8'hc0);
		hit(1'b1, 16'h1234, 16'h5678, 16'h1234);
		chk({8'h00, statusCtrl & 8'he0}, 16'h0080);
		wr(16'h0020, 8'hc0);
		rdchk(16'h0021, 8'h00);
		hit(1'b0, 16'h0000, 16'h5678, 16'h5678);
		wr(16'h0020, 8'h80);
		rdchk(16'h0021, 8'h20);
		wr(16'h0021, 8'h00);
		rdchk(16'h0021, 8'h00);
		wr(16'h0020, 8'h00);
		wr(16'h0028, 8'h08);
		hit(1'b0, 16'h0000, 16'h5678, 16'h5678);
		chk({15'h0000, cBreakRequest}, 16'h0001);
		wr(16'h0028, 8'h80);
		hit(1'b1, 16'h1234, 16'h0000, 16'h1234);
		chk({15'h0000, abBreakRequest}, 16'h0001);
		wr(16'h0028, 8'h00);
	endtask

	task automatic t_hold;
		clkEn <= 1'b0;
		wr(16'h002b, 8'haa);
		clkEn <= 1'b1;
		rdchk(16'h002b, 8'h12);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rdchk(16'h002b, 8'h00);
		rdchk(16'h0020, 8'h00);
	endtask

	task automatic t_tags;
		wr(16'h0028, 8'h10);
		tagUpperReq <= 1'b1;
		repeat (40) @(posedge sys_clk);
		chk({15'h0000, tagHigh}, 16'h0001);
		wideOrNarrowMode <= 1'b1;
		lowByteStrobe    <= 1'b1;
		tagLowerReq      <= 1'b1;
		repeat (40) @(posedge sys_clk);
		chk({15'h0000, tagLow}, 16'h0001);
		lowByteStrobe <= 1'b0;
		repeat (40) @(posedge sys_clk);
		chk({15'h0000, tagLow}, 16'h0000);
		wr(16'h0028, 8'h00);
		repeat (40) @(posedge sys_clk);
		chk({15'h0000, tagHigh}, 16'h0000);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		err_total = 0;
		tests_run = 0;
		cycles = 0;
		sys_rst = 1'b1;
		clkEn = 1'b1;
		regBase = 16'h0000;
		regAddr = 16'h0000;
		regWdata = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		tagUpperReq = 1'b0;
		tagLowerReq = 1'b0;
		wideOrNarrowMode = 1'b0;
		lowByteStrobe = 1'b0;
		busValid = 1'b0;
		extAccess = 1'b0;
		intAddr = 16'h0000;
		extAddr = 16'h0000;
		intData = 16'h0000;
		extData = 16'h0000;
		traceWord = 16'h0000;
		entryCount = 6'h00;
		bufferFullFlag = 1'b0;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_map();
		t_readonly();
		t_ctrl();
		t_match();
		t_tags();
		t_hold();
		final_report();
	end
endmodule // tb
`default_nettype wire
